// file: bench/ssclk_codec_model.sv
// codec partner model: optional bit clock source and frame capture
`timescale 1ns/1ps
module ssclk_codec_model #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic run,
  input wire logic tk_wire,
  input wire logic fs_wire,
  input wire logic data,
  input wire logic neg,
  output logic tk_drv,
  output logic [31:0] got,
  output logic [5:0] nbits
);
  int cnt;
  logic tk_prev;
  // ============================================================
  // bit clock
  // stands still low while run is low; half period of 8 keeps the rate
  // far below the slowest allowed pin ratio, the rx pin is never driven
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      tk_drv <= 1'h0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      tk_drv <= ~tk_drv;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // ============================================================
  // capture
  // data sampled on the chosen bit clock edge only while frame sync is
  // high; the falling edge suits an inverted internal transmit clock
  always_ff @(posedge clk) begin
    tk_prev <= tk_wire;
    if (clr) begin
      got <= 32'h0;
      nbits <= 6'h0;
    end else if ((neg ? (!tk_wire && tk_prev) : (tk_wire && !tk_prev)) &&
                 fs_wire) begin
      got <= {data, got[31:1]};
      nbits <= nbits + 6'h1;
    end
  end
endmodule : ssclk_codec_model

// file: bench/test_sync_serial_clocking_and_tx.sv
// self-checking bench for the serial clock and transmit block
`timescale 1ns/1ps
`include "ssclk_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_sync_serial_clocking_and_tx;
  logic CORE_CLK, RESET, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, IRQ;
  logic [31:0] HADDR, HWDATA, HRDATA, got;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic tk_o, tk_oe, rk_o, rk_oe, fs_o, fs_oe, td, tk_drv, run, clr, neg;
  logic tk_wire, rk_wire, fs_wire;
  logic [5:0] nbits;
  int num_errors = 0;
  int check_count = 0;
  assign HREADY = HREADYOUT;
  // tx clock pin resolved from both ends; frame sync and rx clock pulled low
  assign tk_wire = tk_oe ? tk_o : tk_drv;
  assign rk_wire = rk_oe ? rk_o : 1'h0;
  assign fs_wire = fs_oe ? fs_o : 1'h0;
  ssclk_top uut (.CORE_CLK(CORE_CLK), .RESET(RESET), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .HRDATA(HRDATA), .IRQ(IRQ), .TX_CLOCK_PIN_I(tk_wire),
    .TX_CLOCK_PIN_O(tk_o), .TX_CLOCK_PIN_OE(tk_oe),
    .RX_CLOCK_PIN_I(rk_wire), .RX_CLOCK_PIN_O(rk_o),
    .RX_CLOCK_PIN_OE(rk_oe), .TX_FRAME_SYNC_PIN_I(fs_wire),
    .TX_FRAME_SYNC_PIN_O(fs_o), .TX_FRAME_SYNC_PIN_OE(fs_oe),
    .TX_DATA_PIN(td));
  ssclk_codec_model #(.HALF(8)) partner (.clk(CORE_CLK), .clr(clr),
    .run(run), .tk_wire(tk_wire), .fs_wire(fs_wire), .data(td),
    .neg(neg), .tk_drv(tk_drv), .got(got), .nbits(nbits));
  // ============================================================
  // bus and helpers
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    HSEL <= 1'h1;
    HADDR <= {24'h000000, a};
    HWRITE <= wr;
    HTRANS <= 2'h2;
    do @(posedge CORE_CLK); while (HREADY !== 1'h1);
    HTRANS <= 2'h0;
    HSEL <= 1'h0;
    HWDATA <= wd;
    do @(posedge CORE_CLK); while (HREADY !== 1'h1);
    rd = HRDATA;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'h0, a, 32'h0, x);
    `CHK("register", e, x)
  endtask : rd_chk
  task poll(input logic [1:0] want);
    int i;
    logic [31:0] r;
    for (i = 0; i < 2000; i++) begin
      bus(1'h0, `SSCLK_OFS_STAT, 32'h0, r);
      if (r[1:0] === want) break;
    end
    `CHK("status", want, r[1:0])
  endtask : poll
  task wait_tk(input logic v);
    int i;
    for (i = 0; i < 20000 && tk_o !== v; i++) @(posedge CORE_CLK);
  endtask : wait_tk
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction : rev8
  // ============================================================
  // scenarios
  task t_regs;
    rd_chk(`SSCLK_OFS_STAT, 32'h3);
    rd_chk(`SSCLK_OFS_DIV, 32'h0);
    rd_chk(`SSCLK_OFS_TXFR, 32'h1f);
    rd_chk(8'h40, 32'h0);
    wr(`SSCLK_OFS_DIV, 32'hffffffff);
    rd_chk(`SSCLK_OFS_DIV, 32'hfff);
    wr(`SSCLK_OFS_DIV, 32'h0);
  endtask : t_regs
  task t_div;
    int k, n, j;
    int tbl[3];
    tbl = '{1, 3, 4};
    wr(`SSCLK_OFS_TXCK, 32'h14);
    wr(`SSCLK_OFS_RXCK, 32'h04);
    for (k = 0; k < 3; k++) begin
      wr(`SSCLK_OFS_DIV, 32'(tbl[k]));
      repeat (4) @(posedge CORE_CLK);
      for (j = 0; j < 16; j++) begin
        @(posedge CORE_CLK);
        `CHK("pin clocks", rk_o, tk_o)
      end
      `CHK("tk drive", 1'h1, tk_oe)
      wait_tk(1'h0);
      wait_tk(1'h1);
      for (n = 0; n < 9000 && tk_o === 1'h1; n++) @(posedge CORE_CLK);
      `CHK("high len", tbl[k], n)
      for (n = 0; n < 9000 && tk_o === 1'h0; n++) @(posedge CORE_CLK);
      `CHK("low len", tbl[k], n)
    end
    wr(`SSCLK_OFS_DIV, 32'h0);
    repeat (10) @(posedge CORE_CLK);
    n = 0;
    for (j = 0; j < 40; j++) begin
      @(posedge CORE_CLK);
      if (tk_o !== 1'h0) n++;
    end
    `CHK("idle divider", 0, n)
  endtask : t_div
  task t_word(input logic [31:0] tck, input logic msbf);
    logic [7:0] w1, w2, e1, e2;
    w1 = 8'h1e;
    w2 = 8'h62;
    e1 = msbf ? rev8(w1) : w1;
    e2 = msbf ? rev8(w2) : w2;
    clr <= 1'h1;
    run <= (tck[1:0] == 2'h2);
    neg <= tck[4];
    wr(`SSCLK_OFS_DIV, 32'h2);
    clr <= 1'h0;
    wr(`SSCLK_OFS_TXCK, tck);
    wr(`SSCLK_OFS_TXFR, {23'h0, 1'h1, msbf, 2'h0, 5'h07});
    wr(`SSCLK_OFS_CTRL, 32'h2);
    wr(`SSCLK_OFS_THR, {24'h0, w1});
    poll(2'h1);
    wr(`SSCLK_OFS_THR, {24'h0, w2});
    rd_chk(`SSCLK_OFS_STAT, 32'h0);
    `CHK("tk drive busy", tck[3:2] != 2'h0, tk_oe)
    poll(2'h3);
    repeat (4) @(posedge CORE_CLK);
    `CHK("tk drive idle", 1'h0, tk_oe)
    `CHK("bit count", 6'h10, nbits)
    `CHK("words", {e2, e1}, got[31:16])
    run <= 1'h0;
    wr(`SSCLK_OFS_CTRL, 32'h0);
  endtask : t_word
  task t_start;
    wr(`SSCLK_OFS_TXCK, 32'h100);
    wr(`SSCLK_OFS_CTRL, 32'h2);
    wr(`SSCLK_OFS_THR, 32'h5a);
    repeat (40) @(posedge CORE_CLK);
    rd_chk(`SSCLK_OFS_STAT, 32'h0);
    wr(`SSCLK_OFS_RXCK, 32'h08);
    wr(`SSCLK_OFS_CTRL, 32'h3);
    poll(2'h3);
    `CHK("rk drive", 1'h1, rk_oe)
    wr(`SSCLK_OFS_CTRL, 32'h0);
  endtask : t_start
  task t_irq;
    wr(`SSCLK_OFS_MASK, 32'h1);
    repeat (2) @(posedge CORE_CLK);
    `CHK("irq unmasked", 1'h1, IRQ)
    wr(`SSCLK_OFS_MASK, 32'h0);
    repeat (2) @(posedge CORE_CLK);
    `CHK("irq masked", 1'h0, IRQ)
  endtask : t_irq
  task end_sim;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // ============================================================
  // clock, watchdog and main sequence
  initial begin
    CORE_CLK = 1'h0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    #(8 * 20000);
    num_errors++;
    end_sim;
  end
  initial begin
    RESET = 1'h1;
    HSEL = 1'h0;
    HWRITE = 1'h0;
    HADDR = 32'h0;
    HWDATA = 32'h0;
    HTRANS = 2'h0;
    HSIZE = 3'h2;
    run = 1'h0;
    neg = 1'h0;
    clr = 1'h1;
    repeat (8) @(posedge CORE_CLK);
    RESET <= 1'h0;
    @(posedge CORE_CLK);
    t_regs;
    t_div;
    t_word(32'h08, 1'h0);
    t_word(32'h08, 1'h1);
    t_word(32'h02, 1'h0);
    t_word(32'h19, 1'h0);
    t_start;
    t_irq;
    end_sim;
  end
endmodule : test_sync_serial_clocking_and_tx

// file: hdl/ssclk_div.sv
// master clock divider with equal high and low phases
`timescale 1ns/1ps
module ssclk_div (
  input wire logic clk,
  input wire logic rst,
  ssclk_div_if.gen dv
);
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic clk_reg;
  logic clk_next;
  wire active = dv.divisor != 12'h000;
  // toggle after divisor cycles in the current level
  wire hit = active && (cnt_reg >= 12'(dv.divisor - 12'h001));
  assign cnt_next = (!active || hit) ? 12'h000 : 12'(cnt_reg + 12'h001);
  assign clk_next = active ? (clk_reg ^ hit) : 1'b0;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 12'h000;
      clk_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
    end
  end
  assign dv.div_clk = clk_reg;

  // ============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [11:0] run_reg;
  logic chg_reg;
  always_ff @(posedge clk) begin
    if (rst || hit) begin
      run_reg <= 12'h000;
      chg_reg <= 1'b0;
    end else begin
      run_reg <= 12'(run_reg + 12'h001);
      chg_reg <= chg_reg | (dv.divisor != $past(dv.divisor));
    end
  end
  div_phase_a: assert property (
    (hit && !chg_reg && $stable(dv.divisor) && run_reg != 12'h000) |->
      run_reg == 12'(dv.divisor - 12'h001))
    else $error("divided clock phase length wrong");
  div_idle_a: assert property (
    (dv.divisor == 12'h000 && $stable(dv.divisor)) |=>
      !dv.div_clk && !$changed(dv.div_clk))
    else $error("divider active with zero divisor");
  div_fast_c: cover property (
    dv.divisor == 12'h001 ##1 $rose(dv.div_clk) ##1 $fell(dv.div_clk));
endmodule : ssclk_div

// file: hdl/ssclk_div_if.sv
// divisor and divided clock between top and divider
`timescale 1ns/1ps
interface ssclk_div_if;
  logic [11:0] divisor;
  logic div_clk;
  modport gen (input divisor, output div_clk);
  modport user (output divisor, input div_clk);
endinterface : ssclk_div_if

// file: hdl/ssclk_map.svh
// register map, field positions and reset values of the serial clock block
// ============================================================
// Functional notes
// - divisor is twelve bits, up to 4095
// - divisor zero keeps divider idle
// - divided rate is master over twice divisor
// - each level lasts divisor master cycles
// - one divided clock feeds both sides
// - tx clock: rx clock, divider or pin
// - tx inversion never reaches the tx pin
// - tx pin: none, continuous or transfer only
// - rx clock: tx clock, divider or pin
// - rx inversion never reaches the rx pin
// - rx pin: none, continuous or transfer only
// - tx frame begins only on start event; code begins as soon as a word is held when the start bit is clear
// - holding word moves into tx shifter
// - empty flag when holding and shifter empty
// - ready flag when holding word moves on
// - sides independent, or share clock and start
// - maskable sources drive one interrupt line
`ifndef SSCLK_MAP_SVH
`define SSCLK_MAP_SVH
// ============================================================
// byte offsets
`define SSCLK_OFS_CTRL 8'h00
`define SSCLK_OFS_DIV 8'h04
`define SSCLK_OFS_RXCK 8'h08
`define SSCLK_OFS_TXCK 8'h0c
`define SSCLK_OFS_TXFR 8'h10
`define SSCLK_OFS_THR 8'h14
`define SSCLK_OFS_STAT 8'h18
`define SSCLK_OFS_MASK 8'h1c
// ============================================================
// field positions
`define SSCLK_CTRL_RXEN 0
`define SSCLK_CTRL_TXEN 1
`define SSCLK_DIV_MSB 11
`define SSCLK_CK_CKO_LSB 2
`define SSCLK_CK_CKI 4
`define SSCLK_CK_START 8
`define SSCLK_FR_LEN_MSB 4
`define SSCLK_FR_DATDEF 5
`define SSCLK_FR_MSBF 7
`define SSCLK_FR_FSOUT 8
`define SSCLK_ST_READY 0
`define SSCLK_ST_EMPTY 1
// ============================================================
// reset values
`define SSCLK_RST_CTRL 2'h0
`define SSCLK_RST_DIV 12'h000
`define SSCLK_RST_CK 9'h000
`define SSCLK_RST_TXFR 9'h01f
`define SSCLK_RST_MASK 2'h0
`endif

// file: hdl/ssclk_pkg.sv
// types shared by the serial clock block
package ssclk_pkg;
  typedef enum logic [1:0] {
    SSCLK_CKS_DIV,
    SSCLK_CKS_OTHER,
    SSCLK_CKS_PIN
  } ssclk_cks_t;
  typedef enum logic [1:0] {
    SSCLK_CKO_NONE,
    SSCLK_CKO_CONT,
    SSCLK_CKO_XFER
  } ssclk_cko_t;
  typedef enum logic {
    SSCLK_TX_IDLE,
    SSCLK_TX_SHIFT
  } ssclk_txst_t;
endpackage : ssclk_pkg

// file: hdl/ssclk_top.sv
// serial clock management and transmit path behind an AHB-Lite slave
`timescale 1ns/1ps
`include "ssclk_map.svh"
module ssclk_top import ssclk_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  output logic IRQ,
  input wire logic TX_CLOCK_PIN_I,
  output logic TX_CLOCK_PIN_O,
  output logic TX_CLOCK_PIN_OE,
  input wire logic RX_CLOCK_PIN_I,
  output logic RX_CLOCK_PIN_O,
  output logic RX_CLOCK_PIN_OE,
  input wire logic TX_FRAME_SYNC_PIN_I,
  output logic TX_FRAME_SYNC_PIN_O,
  output logic TX_FRAME_SYNC_PIN_OE,
  output logic TX_DATA_PIN
);

  // ============================================================
  // helpers
  function automatic logic sel_src(input ssclk_cks_t clock_source_select,
                                   input logic other,
                                   input logic pin,
                                   input logic divc);
    logic s;
    s = divc;
    unique case (clock_source_select)
      SSCLK_CKS_DIV: s = divc;
      SSCLK_CKS_OTHER: s = other;
      SSCLK_CKS_PIN: s = pin;
      default: s = divc;
    endcase
    return s;
  endfunction : sel_src

  function automatic logic [4:0] bit_index(input logic [4:0] pos,
                                           input logic [4:0] len,
                                           input logic msbf);
    return msbf ? 5'(len - pos) : pos;
  endfunction : bit_index

  function automatic logic pin_drive(input ssclk_cko_t clock_output_mode,
                                     input logic xfer);
    logic d;
    d = 1'b0;
    unique case (clock_output_mode)
      SSCLK_CKO_NONE: d = 1'b0;
      SSCLK_CKO_CONT: d = 1'b1;
      SSCLK_CKO_XFER: d = xfer;
      default: d = 1'b0;
    endcase
    return d;
  endfunction : pin_drive

  // ============================================================
  // pin synchronisers
  logic [2:0] sy1_reg;
  logic [2:0] sy2_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sy1_reg <= 3'h0;
      sy2_reg <= 3'h0;
    end else begin
      sy1_reg <= {TX_FRAME_SYNC_PIN_I, RX_CLOCK_PIN_I, TX_CLOCK_PIN_I};
      sy2_reg <= sy1_reg;
    end
  end
  wire tk_s = sy2_reg[0];
  wire rk_s = sy2_reg[1];

  // ============================================================
  // bus slave
  logic [1:0] ctrl_reg;
  logic [11:0] div_reg;
  logic [8:0] rxck_reg;
  logic [8:0] txck_reg;
  logic [8:0] txfr_reg;
  logic [1:0] mask_reg;
  logic [31:0] thr_reg;
  logic wr_pend_reg;
  logic [7:0] wa_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] stat;

  // zero wait states, so every transfer completes in its data phase
  wire take = HSEL && HREADY && HTRANS[1];
  wire w_ctrl = wr_pend_reg && (wa_reg == `SSCLK_OFS_CTRL);
  wire w_div = wr_pend_reg && (wa_reg == `SSCLK_OFS_DIV);
  wire w_rxck = wr_pend_reg && (wa_reg == `SSCLK_OFS_RXCK);
  wire w_txck = wr_pend_reg && (wa_reg == `SSCLK_OFS_TXCK);
  wire w_txfr = wr_pend_reg && (wa_reg == `SSCLK_OFS_TXFR);
  wire w_thr = wr_pend_reg && (wa_reg == `SSCLK_OFS_THR);
  wire w_mask = wr_pend_reg && (wa_reg == `SSCLK_OFS_MASK);

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (HADDR[7:0])
      `SSCLK_OFS_CTRL: rdata_next = {30'h0, ctrl_reg};
      `SSCLK_OFS_DIV: rdata_next = {20'h0, div_reg};
      `SSCLK_OFS_RXCK: rdata_next = {23'h0, rxck_reg};
      `SSCLK_OFS_TXCK: rdata_next = {23'h0, txck_reg};
      `SSCLK_OFS_TXFR: rdata_next = {23'h0, txfr_reg};
      `SSCLK_OFS_STAT: rdata_next = {30'h0, stat};
      `SSCLK_OFS_MASK: rdata_next = {30'h0, mask_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      wr_pend_reg <= 1'b0;
      wa_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= take && HWRITE;
      wa_reg <= take ? HADDR[7:0] : wa_reg;
      rdata_reg <= (take && !HWRITE) ? rdata_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl_reg <= `SSCLK_RST_CTRL;
      div_reg <= `SSCLK_RST_DIV;
      rxck_reg <= `SSCLK_RST_CK;
      txck_reg <= `SSCLK_RST_CK;
      txfr_reg <= `SSCLK_RST_TXFR;
      mask_reg <= `SSCLK_RST_MASK;
      thr_reg <= 32'h0000_0000;
    end else begin
      if (w_ctrl) ctrl_reg <= HWDATA[1:0];
      if (w_div) div_reg <= HWDATA[`SSCLK_DIV_MSB:0];
      if (w_rxck) rxck_reg <= HWDATA[8:0];
      if (w_txck) txck_reg <= HWDATA[8:0];
      if (w_txfr) txfr_reg <= HWDATA[8:0];
      if (w_mask) mask_reg <= HWDATA[1:0];
      if (w_thr) thr_reg <= HWDATA;
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_reg;

  // ============================================================
  // clock divider
  ssclk_div_if dvif ();
  assign dvif.divisor = div_reg;
  ssclk_div u_div (
    .clk(CORE_CLK),
    .rst(RESET),
    .dv(dvif.gen)
  );
  wire div_clk = dvif.div_clk;

  // ============================================================
  // clock selection
  wire ssclk_cks_t tx_cks = ssclk_cks_t'(txck_reg[1:0]);
  wire ssclk_cks_t rx_cks = ssclk_cks_t'(rxck_reg[1:0]);
  wire ssclk_cko_t tx_cko =
    ssclk_cko_t'(txck_reg[`SSCLK_CK_CKO_LSB+1:`SSCLK_CK_CKO_LSB]);
  wire ssclk_cko_t rx_cko =
    ssclk_cko_t'(rxck_reg[`SSCLK_CK_CKO_LSB+1:`SSCLK_CK_CKO_LSB]);
  // each side lends the other only its own non-borrowed source, so a
  // mutual selection cannot form a loop; both then fall back to the divider
  wire tx_base = sel_src(tx_cks, div_clk, tk_s, div_clk);
  wire rx_base = sel_src(rx_cks, div_clk, rk_s, div_clk);
  wire tx_src = sel_src(tx_cks, rx_base, tk_s, div_clk);
  wire rx_src = sel_src(rx_cks, tx_base, rk_s, div_clk);
  wire tx_ck = tx_src ^ txck_reg[`SSCLK_CK_CKI];
  wire rx_ck = rx_src ^ rxck_reg[`SSCLK_CK_CKI];
  logic tx_ck_d_reg;
  logic rx_ck_d_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      tx_ck_d_reg <= 1'b0;
      rx_ck_d_reg <= 1'b0;
    end else begin
      tx_ck_d_reg <= tx_ck;
      rx_ck_d_reg <= rx_ck;
    end
  end
  // data changes on the falling edge so the partner samples on the rising
  wire tx_fall = tx_ck_d_reg && !tx_ck;
  wire rx_edge = rx_ck_d_reg != rx_ck;

  // ============================================================
  // start control
  logic rx_run_reg;
  logic rx_run_next;
  ssclk_txst_t st_reg;
  ssclk_txst_t st_next;
  wire rx_en = ctrl_reg[`SSCLK_CTRL_RXEN];
  wire tx_en = ctrl_reg[`SSCLK_CTRL_TXEN];
  wire tx_busy = st_reg == SSCLK_TX_SHIFT;
  // receiver running: at its first clock edge, or with the transmitter
  assign rx_run_next = rx_en && (rx_run_reg || (rxck_reg[`SSCLK_CK_START] ?
                       tx_busy : rx_edge));
  wire tx_go = tx_en && (!txck_reg[`SSCLK_CK_START] || rx_run_reg);

  // ============================================================
  // transmit path
  logic thr_full_reg;
  logic thr_full_next;
  logic [31:0] word_reg;
  logic [4:0] pos_reg;
  logic [4:0] pos_next;
  logic td_reg;
  wire [4:0] len = txfr_reg[`SSCLK_FR_LEN_MSB:0];
  wire last = pos_reg == len;
  wire load = tx_fall && tx_go && thr_full_reg &&
              (!tx_busy || last);

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      SSCLK_TX_IDLE: if (load) st_next = SSCLK_TX_SHIFT;
      SSCLK_TX_SHIFT: begin
        if (tx_fall && last && !load) st_next = SSCLK_TX_IDLE;
      end
    endcase
  end
  assign pos_next = load ? 5'h00 :
                    (tx_busy && tx_fall) ? 5'(pos_reg + 5'h01) : pos_reg;
  // a word written in the cycle of the move is kept: set wins
  assign thr_full_next = w_thr || (thr_full_reg && !load);

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_reg <= SSCLK_TX_IDLE;
      rx_run_reg <= 1'b0;
      thr_full_reg <= 1'b0;
      word_reg <= 32'h0000_0000;
      pos_reg <= 5'h00;
    end else begin
      st_reg <= st_next;
      rx_run_reg <= rx_run_next;
      thr_full_reg <= thr_full_next;
      pos_reg <= pos_next;
      if (load) word_reg <= thr_reg;
    end
  end

  // ============================================================
  // status and interrupt
  wire tx_ready = !thr_full_reg;
  wire tx_empty = !thr_full_reg && !tx_busy;
  assign stat = {tx_empty, tx_ready};
  wire irq_next = |(stat & mask_reg);
  logic irq_reg;

  // ============================================================
  // pin drivers
  logic tko_reg;
  logic tkoe_reg;
  logic rko_reg;
  logic rkoe_reg;
  logic tfo_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      irq_reg <= 1'b0;
      tko_reg <= 1'b0;
      tkoe_reg <= 1'b0;
      rko_reg <= 1'b0;
      rkoe_reg <= 1'b0;
      tfo_reg <= 1'b0;
      td_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
      tko_reg <= tx_src;
      tkoe_reg <= pin_drive(tx_cko, tx_busy);
      rko_reg <= rx_src;
      rkoe_reg <= pin_drive(rx_cko, rx_run_reg);
      tfo_reg <= txfr_reg[`SSCLK_FR_FSOUT] && tx_busy;
      td_reg <= tx_busy ?
        word_reg[bit_index(pos_reg, len, txfr_reg[`SSCLK_FR_MSBF])] :
        txfr_reg[`SSCLK_FR_DATDEF];
    end
  end
  assign IRQ = irq_reg;
  assign TX_CLOCK_PIN_O = tko_reg;
  assign TX_CLOCK_PIN_OE = tkoe_reg;
  assign RX_CLOCK_PIN_O = rko_reg;
  assign RX_CLOCK_PIN_OE = rkoe_reg;
  assign TX_FRAME_SYNC_PIN_O = tfo_reg;
  assign TX_FRAME_SYNC_PIN_OE = txfr_reg[`SSCLK_FR_FSOUT];
  assign TX_DATA_PIN = td_reg;

  // ============================================================
  // checks
  default clocking mcb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("slave answer not ready and okay");
  empty_write_a: assert property (w_thr |=> !tx_empty)
    else $error("empty flag stayed set after holding write");
  empty_idle_a: assert property (
    (!tx_busy && !thr_full_reg) |-> stat[`SSCLK_ST_EMPTY])
    else $error("empty flag clear with nothing pending");
  ready_load_a: assert property (
    (load && !w_thr) |=> tx_ready && tx_busy && pos_reg == 5'h00)
    else $error("ready flag not set on move to shifter");
  start_hold_a: assert property (
    (txck_reg[`SSCLK_CK_START] && !rx_run_reg) |-> !load)
    else $error("transmit started before receiver start");
  shift_walk_a: assert property (
    (tx_busy && tx_fall && !last) |=> pos_reg == $past(pos_reg) + 5'h01)
    else $error("shifter position did not advance");
  tx_pin_a: assert property (
    ##1 TX_CLOCK_PIN_O == $past(tx_src))
    else $error("tx clock pin altered by inversion");
  tx_none_a: assert property (
    (tx_cko == SSCLK_CKO_NONE) |=> !TX_CLOCK_PIN_OE)
    else $error("tx clock pin driven while disabled");
  tx_xfer_a: assert property (
    (tx_cko == SSCLK_CKO_XFER) |=> TX_CLOCK_PIN_OE == $past(tx_busy))
    else $error("tx clock pin drive not tied to transfer");
  rx_cont_a: assert property (
    (rx_cko == SSCLK_CKO_CONT) |=> RX_CLOCK_PIN_OE)
    else $error("rx clock pin not driven continuously");
  irq_mask_a: assert property (
    ##1 IRQ == $past(|(stat & mask_reg)))
    else $error("interrupt line disagrees with masked status");

  load_c: cover property (load ##[1:64] tx_fall && last);
  back_c: cover property (tx_busy && load);
  irq_c: cover property ($rose(IRQ));
endmodule : ssclk_top
